// ==== inc/sdp_pkg.sv ====
// Constants, pin bundle and state type for the SDRAM port transfer and bus-hold block
package sdp_pkg;
    // Register byte offsets
    localparam logic [3:0] REG_GLOBAL = 4'h0;
    localparam logic [3:0] REG_DIRECT = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    // Global control fields
    localparam int GLB_INHIBIT_BIT = 0;
    localparam int GLB_FLOAT_LSB = 1;
    localparam int GLB_CLKSEL_LSB = 4;
    localparam logic [31:0] GLB_RESET = 32'h0000_0000;
    // Direct transfer control fields
    localparam int DIR_RL_LSB = 0;
    localparam int DIR_WL_LSB = 4;
    localparam logic [31:0] DIR_RESET = 32'h0000_0000;
    // Port clock sources
    localparam logic [1:0] CLKSEL_EXT = 2'h0;
    localparam logic [1:0] CLKSEL_DIV4 = 2'h1;
    localparam logic [1:0] CLKSEL_DIV6 = 2'h2;
    localparam logic [2:0] DIV4_COUNT = 3'h4;
    localparam logic [2:0] DIV6_COUNT = 3'h6;
    // Handshake delays and CAS latency in port clock periods
    localparam logic [2:0] HOLD_FLOAT_MIN_E = 3'h2;
    localparam logic [2:0] HOLD_REDRIVE_MIN_E = 3'h2;
    localparam logic [2:0] HOLD_REDRIVE_MAX_E = 3'h7;
    localparam logic [2:0] CAS_LATENCY = 3'h3;
    // SDRAM commands as {row, column, write}, chip select low
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_ACTV = 3'h3;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_BANK_DEACTIVATE_COMMAND = 3'h2;
    localparam logic [2:0] CMD_REFRESH_COMMAND = 3'h1;
    localparam logic [3:0] CS_NONE = 4'hf;
    localparam logic [3:0] CS_ALL = 4'h0;
    localparam logic [3:0] CS_FIRST = 4'he;

    typedef struct packed {
        logic [3:0] memory_chip_select_n;
        logic sdram_row_strobe_n;
        logic sdram_column_strobe_n;
        logic sdram_write_enable_n;
        logic sdram_clock_enable;
        logic [3:0] memory_byte_enable_n;
        logic [22:3] memory_address_bus;
        logic extra_output_enable_n;
    } sdp_pins_t;

    localparam sdp_pins_t PINS_IDLE = '{CS_NONE, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 20'h0, 1'b1};

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ACT = 4'h1,
        ST_RW = 4'h3,
        ST_DATA = 4'h2,
        ST_BANK_DEACTIVATE_COMMAND = 4'h6,
        ST_REFRESH_COMMAND = 4'h7,
        ST_HWAIT = 4'h5,
        ST_FLOAT = 4'h4,
        ST_HELD = 4'hc,
        ST_RWAIT = 4'hd,
        ST_REGRANT = 4'hf
    } sdp_state_t;
endpackage

// ==== rtl/sdp_port.sv ====
// SDRAM port: strobe reuse, direct-transfer strobe and bus-hold handshake
// Overview of operation
// - Shared strobes act as column, write, row
// - Read strobe only with source option set
// - Write strobe only with destination option set
// - Direct read data is not captured
// - Direct write leaves data bus floating
// - Read strobe delayed zero to three periods
// - Write strobe delayed zero to three periods
// - Pending transactions finish before grant
// - Inhibit bit holds grant off while set
// - Output clocks toggle or float per select
// - Float two periods after request, then grant
// - Redrive two to seven periods, then ungrant
// - Floated clocks follow same hold timing
// - Float chip selects, enables, data, address, strobes
// - Delays count port clock from three sources
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module sdp_port (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic port_input_clock_pin,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic direct_src_option_bit,
    input wire logic direct_dst_option_bit,
    input wire logic [22:3] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic [3:0] req_byte_enable_n,
    output logic req_ready,
    input wire logic refresh_req,
    output logic rd_valid,
    output logic [31:0] rd_data,
    input wire logic bus_yield_request_n,
    output logic bus_yield_grant_n,
    output logic [1:0] memory_output_clock,
    output logic [1:0] memory_output_clock_oe_n,
    output sdp_pkg::sdp_pins_t mem_pins,
    output logic mem_pins_oe_n,
    input wire logic [31:0] memory_data_bus_in,
    output logic [31:0] memory_data_bus_out,
    output logic memory_data_bus_oe_n,
    output logic direct_transfer_strobe
);
    logic [31:0] port_global_control_reg;
    logic [31:0] direct_transfer_control_reg;
    logic pin_q;
    logic [2:0] div_cnt;
    logic tick;
    sdp_pkg::sdp_state_t state;
    sdp_pkg::sdp_state_t next_state;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic pend;
    logic ref_pend;
    logic cur_write;
    logic cur_direct;
    logic [22:3] cur_addr;
    logic [31:0] cur_wdata;
    logic [3:0] cur_be_n;
    logic [3:0] dp_sh;
    logic [2:0] ycnt;
    logic yreq_q;
    sdp_pkg::sdp_pins_t next_pins;
    logic next_pins_oe_n;
    logic next_data_oe_n;
    logic next_grant_n;
    logic next_clk_float;
    logic clk_float;
    logic dp_start;
    logic capture;
    logic launch;
    logic accept;
    logic strobe_sel;

    // Field decode
    wire logic inhibit = port_global_control_reg[sdp_pkg::GLB_INHIBIT_BIT];
    wire logic [1:0] float_sel = port_global_control_reg[sdp_pkg::GLB_FLOAT_LSB +: 2];
    wire logic [1:0] clk_sel = port_global_control_reg[sdp_pkg::GLB_CLKSEL_LSB +: 2];
    wire logic [1:0] read_lat = direct_transfer_control_reg[sdp_pkg::DIR_RL_LSB +: 2];
    wire logic [1:0] write_lat = direct_transfer_control_reg[sdp_pkg::DIR_WL_LSB +: 2];
    wire logic [1:0] cur_lat = cur_write ? write_lat : read_lat;
    wire logic [2:0] div_end = (clk_sel == sdp_pkg::CLKSEL_DIV6) ? sdp_pkg::DIV6_COUNT
                                                                  : sdp_pkg::DIV4_COUNT;
    wire logic yield_req = !bus_yield_request_n;
    wire logic [31:0] status_word = {24'h0, 2'h0, clk_float, bus_yield_grant_n, state};

    // Port clock enable from the external pin or a divided reference
    assign tick = (clk_sel == sdp_pkg::CLKSEL_EXT) ? (port_input_clock_pin && !pin_q)
                                                    : (div_cnt == div_end - 3'h1);
    assign accept = req_valid && req_ready;
    assign launch = tick && (next_state == sdp_pkg::ST_ACT);
    assign strobe_sel = (cur_lat == 2'h0) ? dp_start : dp_sh[cur_lat - 2'h1];

    // Port clock divider
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_q <= 1'b0;
            div_cnt <= 3'h0;
        end
        else
        begin
            pin_q <= port_input_clock_pin;
            div_cnt <= tick ? 3'h0 : div_cnt + 3'h1;
        end
    end

    // Register writes and delayed read data
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            port_global_control_reg <= sdp_pkg::GLB_RESET;
            direct_transfer_control_reg <= sdp_pkg::DIR_RESET;
            reg_rdata <= 32'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == sdp_pkg::REG_GLOBAL)
                port_global_control_reg <= {26'h0, reg_wdata[5:0]};
            if (reg_wr && reg_addr == sdp_pkg::REG_DIRECT)
                direct_transfer_control_reg <= {26'h0, reg_wdata[5:4], 2'h0, reg_wdata[1:0]};
            if (!reg_rd)
                reg_rdata <= 32'h0;
            else if (reg_addr == sdp_pkg::REG_GLOBAL)
                reg_rdata <= port_global_control_reg;
            else if (reg_addr == sdp_pkg::REG_DIRECT)
                reg_rdata <= direct_transfer_control_reg;
            else if (reg_addr == sdp_pkg::REG_STATUS)
                reg_rdata <= status_word;
            else
                reg_rdata <= 32'h0;
        end
    end

    // Request and refresh capture; set wins over clear
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pend <= 1'b0;
            ref_pend <= 1'b0;
            req_ready <= 1'b0;
            cur_write <= 1'b0;
            cur_direct <= 1'b0;
            cur_addr <= 20'h0;
            cur_wdata <= 32'h0;
            cur_be_n <= 4'hf;
        end
        else
        begin
            pend <= accept || (pend && !launch);
            ref_pend <= refresh_req || (ref_pend && !(tick && next_state == sdp_pkg::ST_REFRESH_COMMAND));
            req_ready <= !accept && !pend && state == sdp_pkg::ST_IDLE && bus_yield_grant_n;
            if (accept)
            begin
                cur_write <= req_write;
                cur_direct <= req_write ? direct_dst_option_bit : direct_src_option_bit;
                cur_addr <= req_addr;
                cur_wdata <= req_wdata;
                cur_be_n <= req_byte_enable_n;
            end
        end
    end

    // Sequencer: next state, pin command and float control
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_pins = mem_pins;
        next_pins.sdram_row_strobe_n = 1'b1;
        next_pins.sdram_column_strobe_n = 1'b1;
        next_pins.sdram_write_enable_n = 1'b1;
        next_pins.memory_chip_select_n = sdp_pkg::CS_NONE;
        next_pins_oe_n = mem_pins_oe_n;
        next_data_oe_n = memory_data_bus_oe_n;
        next_grant_n = bus_yield_grant_n;
        next_clk_float = clk_float;
        dp_start = 1'b0;
        capture = 1'b0;
        unique case (state)
            sdp_pkg::ST_IDLE:
            begin
                if (pend)
                begin
                    next_state = sdp_pkg::ST_ACT;
                    next_pins.memory_chip_select_n = sdp_pkg::CS_FIRST;
                    {next_pins.sdram_row_strobe_n, next_pins.sdram_column_strobe_n,
                        next_pins.sdram_write_enable_n} = sdp_pkg::CMD_ACTV;
                    next_pins.memory_address_bus = cur_addr;
                end
                else if (ref_pend)
                begin
                    next_state = sdp_pkg::ST_REFRESH_COMMAND;
                    next_pins.memory_chip_select_n = sdp_pkg::CS_ALL;
                    {next_pins.sdram_row_strobe_n, next_pins.sdram_column_strobe_n,
                        next_pins.sdram_write_enable_n} = sdp_pkg::CMD_REFRESH_COMMAND;
                end
                else if (yield_req && !inhibit)
                begin
                    next_state = sdp_pkg::ST_HWAIT;
                    next_cnt = 3'h0;
                end
            end
            sdp_pkg::ST_ACT:
            begin
                next_state = sdp_pkg::ST_RW;
                next_pins.memory_chip_select_n = sdp_pkg::CS_FIRST;
                next_pins.memory_byte_enable_n = cur_be_n;
                {next_pins.sdram_row_strobe_n, next_pins.sdram_column_strobe_n,
                    next_pins.sdram_write_enable_n} = cur_write ? sdp_pkg::CMD_WRITE
                                                                : sdp_pkg::CMD_READ;
                next_data_oe_n = !cur_write || cur_direct;
                dp_start = cur_write && cur_direct;
                next_cnt = 3'h1;
            end
            sdp_pkg::ST_RW:
            begin
                next_state = cur_write ? sdp_pkg::ST_BANK_DEACTIVATE_COMMAND : sdp_pkg::ST_DATA;
                next_data_oe_n = 1'b1;
                if (cur_write)
                begin
                    next_pins.memory_chip_select_n = sdp_pkg::CS_FIRST;
                    {next_pins.sdram_row_strobe_n, next_pins.sdram_column_strobe_n,
                        next_pins.sdram_write_enable_n} = sdp_pkg::CMD_BANK_DEACTIVATE_COMMAND;
                end
            end
            sdp_pkg::ST_DATA:
            begin
                next_cnt = cnt + 3'h1;
                if (cnt == sdp_pkg::CAS_LATENCY - 3'h1)
                begin
                    next_state = sdp_pkg::ST_BANK_DEACTIVATE_COMMAND;
                    capture = !cur_direct;
                    dp_start = cur_direct;
                    next_pins.memory_chip_select_n = sdp_pkg::CS_FIRST;
                    {next_pins.sdram_row_strobe_n, next_pins.sdram_column_strobe_n,
                        next_pins.sdram_write_enable_n} = sdp_pkg::CMD_BANK_DEACTIVATE_COMMAND;
                end
            end
            sdp_pkg::ST_BANK_DEACTIVATE_COMMAND, sdp_pkg::ST_REFRESH_COMMAND:
                next_state = sdp_pkg::ST_IDLE;
            sdp_pkg::ST_HWAIT:
            begin
                next_cnt = cnt + 3'h1;
                if (!yield_req || inhibit || pend || ref_pend)
                    next_state = sdp_pkg::ST_IDLE;
                else if (cnt == sdp_pkg::HOLD_FLOAT_MIN_E - 3'h1)
                begin
                    next_state = sdp_pkg::ST_FLOAT;
                    next_pins_oe_n = 1'b1;
                    next_clk_float = 1'b1;
                end
            end
            sdp_pkg::ST_FLOAT:
            begin
                next_state = sdp_pkg::ST_HELD;
                next_grant_n = 1'b0;
            end
            sdp_pkg::ST_HELD:
            begin
                if (!yield_req)
                begin
                    next_state = sdp_pkg::ST_RWAIT;
                    next_cnt = 3'h0;
                end
            end
            sdp_pkg::ST_RWAIT:
            begin
                next_cnt = cnt + 3'h1;
                if (cnt == sdp_pkg::HOLD_REDRIVE_MIN_E - 3'h1)
                begin
                    next_state = sdp_pkg::ST_REGRANT;
                    next_pins_oe_n = 1'b0;
                    next_clk_float = 1'b0;
                end
            end
            sdp_pkg::ST_REGRANT:
            begin
                next_state = sdp_pkg::ST_IDLE;
                next_grant_n = 1'b1;
            end
            default:
                next_state = sdp_pkg::ST_IDLE;
        endcase
    end

    // Sequencer registers advance on the port clock enable
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= sdp_pkg::ST_IDLE;
            cnt <= 3'h0;
            mem_pins <= sdp_pkg::PINS_IDLE;
            mem_pins_oe_n <= 1'b0;
            memory_data_bus_oe_n <= 1'b1;
            memory_data_bus_out <= 32'h0;
            bus_yield_grant_n <= 1'b1;
            clk_float <= 1'b0;
        end
        else if (tick)
        begin
            state <= next_state;
            cnt <= next_cnt;
            mem_pins <= next_pins;
            mem_pins_oe_n <= next_pins_oe_n;
            memory_data_bus_oe_n <= next_data_oe_n;
            memory_data_bus_out <= cur_wdata;
            bus_yield_grant_n <= next_grant_n;
            clk_float <= next_clk_float;
        end
    end

    // Read capture, direct strobe delay line and output clocks
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_valid <= 1'b0;
            rd_data <= 32'h0;
            dp_sh <= 4'h0;
            direct_transfer_strobe <= 1'b0;
            memory_output_clock <= 2'h0;
            memory_output_clock_oe_n <= 2'h0;
        end
        else
        begin
            rd_valid <= tick && capture;
            if (tick && capture)
                rd_data <= memory_data_bus_in;
            if (tick)
            begin
                dp_sh <= {dp_sh[2:0], dp_start};
                direct_transfer_strobe <= strobe_sel;
            end
            memory_output_clock <= {2{tick}};
            memory_output_clock_oe_n <= {2{clk_float}} & float_sel;
        end
    end

    // Checker helper: port periods since the request last changed
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            yreq_q <= 1'b0;
            ycnt <= 3'h0;
        end
        else
        begin
            yreq_q <= yield_req;
            if (yreq_q != yield_req)
                ycnt <= 3'h0;
            else if (tick && ycnt != 3'h7)
                ycnt <= ycnt + 3'h1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_float_min;
        $rose(mem_pins_oe_n) |-> yield_req && ycnt >= sdp_pkg::HOLD_FLOAT_MIN_E;
    endproperty
    a_float_min: assert property (p_float_min) else $error("Bus floated too early");

    property p_grant_after_float;
        $rose(mem_pins_oe_n) && clk_sel != sdp_pkg::CLKSEL_EXT |-> ##[1:13] $fell(bus_yield_grant_n);
    endproperty
    a_grant_after_float: assert property (p_grant_after_float) else $error("Grant late");

    property p_grant_floated;
        !bus_yield_grant_n && state != sdp_pkg::ST_REGRANT
            |-> mem_pins_oe_n && memory_data_bus_oe_n;
    endproperty
    a_grant_floated: assert property (p_grant_floated) else $error("Bus driven in grant");

    property p_redrive_window;
        $fell(mem_pins_oe_n) |-> !yield_req && ycnt >= sdp_pkg::HOLD_REDRIVE_MIN_E
            && ycnt <= sdp_pkg::HOLD_REDRIVE_MAX_E;
    endproperty
    a_redrive_window: assert property (p_redrive_window) else $error("Redrive off window");

    property p_inhibit;
        inhibit && bus_yield_grant_n |=> bus_yield_grant_n;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("Grant while inhibited");

    property p_no_cmd_in_grant;
        !bus_yield_grant_n |=> mem_pins.memory_chip_select_n == sdp_pkg::CS_NONE && !launch;
    endproperty
    a_no_cmd_in_grant: assert property (p_no_cmd_in_grant) else $error("Access in grant");

    property p_direct_write_hiz;
        state == sdp_pkg::ST_RW && cur_write && cur_direct |-> memory_data_bus_oe_n;
    endproperty
    a_direct_write_hiz: assert property (p_direct_write_hiz) else $error("Data driven");

    property p_no_capture;
        rd_valid |-> !cur_direct && $past(state) == sdp_pkg::ST_DATA;
    endproperty
    a_no_capture: assert property (p_no_capture) else $error("Direct read captured");

    property p_command_after_act;
        tick && state == sdp_pkg::ST_ACT |=> {mem_pins.sdram_row_strobe_n,
            mem_pins.sdram_column_strobe_n, mem_pins.sdram_write_enable_n}
            == (cur_write ? sdp_pkg::CMD_WRITE : sdp_pkg::CMD_READ);
    endproperty
    a_command_after_act: assert property (p_command_after_act) else $error("Bad command");

    property p_strobe_zero_lat;
        tick && dp_start && cur_lat == 2'h0 |=> direct_transfer_strobe;
    endproperty
    a_strobe_zero_lat: assert property (p_strobe_zero_lat) else $error("Strobe missing");

    property p_clock_runs;
        !bus_yield_grant_n && !float_sel[0] |-> !memory_output_clock_oe_n[0];
    endproperty
    a_clock_runs: assert property (p_clock_runs) else $error("Clock floated");

    c_hold_cycle: cover property ($fell(bus_yield_grant_n));
    c_direct_read: cover property (direct_transfer_strobe && !cur_write);
    c_refresh: cover property (tick && state == sdp_pkg::ST_REFRESH_COMMAND);
endmodule // sdp_port

// ==== bench/sdp_sdram_model.sv ====
// SDRAM partner model that keeps written words and answers read commands
`timescale 1ns/1ps
module sdp_sdram_model (
    input wire logic ref_clk,
    input wire logic [1:0] memory_output_clock,
    input wire sdp_pkg::sdp_pins_t mem_pins,
    input wire logic [31:0] memory_data_bus_out,
    input wire logic memory_data_bus_oe_n,
    output logic [31:0] memory_data_bus_in = 32'h0
);
    logic [31:0] mem [int];
    logic [31:0] word = 32'h0;
    logic busy = 1'b0;
    int wa = 0;
    logic [2:0] cmd;
    assign cmd = {mem_pins.sdram_row_strobe_n, mem_pins.sdram_column_strobe_n,
        mem_pins.sdram_write_enable_n};
    // Decode on clock pulses; an unanswered bus changes every cycle
    always @(posedge ref_clk)
    begin
        if (memory_output_clock[0] && mem_pins.memory_chip_select_n != sdp_pkg::CS_NONE)
        begin
            if (cmd == sdp_pkg::CMD_WRITE) wa = int'(mem_pins.memory_address_bus);
            if (cmd == sdp_pkg::CMD_READ) word <= mem.exists(int'(mem_pins.memory_address_bus)) ?
                mem[int'(mem_pins.memory_address_bus)] : 32'h0;
            busy <= (cmd == sdp_pkg::CMD_READ) | (busy & (cmd != sdp_pkg::CMD_BANK_DEACTIVATE_COMMAND));
        end
        if (!memory_data_bus_oe_n) mem[wa] = memory_data_bus_out;
        memory_data_bus_in <= busy ? word : ~memory_data_bus_in;
    end
endmodule // sdp_sdram_model

// ==== bench/sdp_port_bench.sv ====
// Self-checking bench for the SDRAM port block
`timescale 1ns/1ps
module sdp_port_bench;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic port_input_clock_pin = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic direct_src_option_bit = 1'b0;
    logic direct_dst_option_bit = 1'b0;
    logic [22:3] req_addr = 20'h0;
    logic [31:0] req_wdata = 32'h0;
    logic [3:0] req_byte_enable_n = 4'h0;
    logic refresh_req = 1'b0;
    logic bus_yield_request_n = 1'b1;
    logic [31:0] reg_rdata, rd_data, memory_data_bus_in, memory_data_bus_out;
    logic req_ready, rd_valid, bus_yield_grant_n, mem_pins_oe_n, memory_data_bus_oe_n;
    logic direct_transfer_strobe, rd_seen = 1'b0, stb_d = 1'b0, drv_seen = 1'b0;
    logic [1:0] memory_output_clock, memory_output_clock_oe_n;
    sdp_pkg::sdp_pins_t mem_pins;
    logic [31:0] rq[$];
    logic [31:0] dq[$];
    logic [31:0] shadow [int];
    logic [31:0] seed = 32'h0159;
    int cyc = 0, tick = 0, cmd_tick = 0, stb_tick = 0, stb_n = 0, bad_count = 0, n_checks = 0;

    sdp_port i_sdp_port (
        .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .port_input_clock_pin, .req_valid, .req_write, .direct_src_option_bit,
        .direct_dst_option_bit, .req_addr, .req_wdata, .req_byte_enable_n, .req_ready,
        .refresh_req, .rd_valid, .rd_data, .bus_yield_request_n, .bus_yield_grant_n,
        .memory_output_clock, .memory_output_clock_oe_n, .mem_pins, .mem_pins_oe_n,
        .memory_data_bus_in, .memory_data_bus_out, .memory_data_bus_oe_n,
        .direct_transfer_strobe
    );
    sdp_sdram_model i_sdp_sdram_model (
        .ref_clk, .memory_output_clock, .mem_pins, .memory_data_bus_out,
        .memory_data_bus_oe_n, .memory_data_bus_in
    );

    // Clock
    always #2.5 ref_clk = ~ref_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic rw(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rr(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 400; i++)
        begin
            @(posedge ref_clk);
            if (req_ready === 1'b1) break;
        end
    endtask
    // One access; a hold request may follow right after it is taken
    task automatic access(input logic w, input logic dir, input logic [22:3] a, input logic hold);
        seed = lfsr(seed);
        if (w && !dir) shadow[int'(a)] = seed;
        if (!w && !dir) dq.push_back(shadow.exists(int'(a)) ? shadow[int'(a)] : 32'h0);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_write <= w;
        direct_src_option_bit <= dir & ~w;
        direct_dst_option_bit <= dir & w;
        req_addr <= a;
        req_wdata <= seed;
        req_byte_enable_n <= seed[7:4];
        wait_ready();
        req_valid <= 1'b0;
        if (hold) bus_yield_request_n <= 1'b0;
        if (hold) return;
        wait_ready();
        repeat (40) @(posedge ref_clk);
    endtask

    // Output watcher: takes the oldest note at each result, counts ticks and strobes
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        port_input_clock_pin <= cyc[1];
        rd_seen <= reg_rd;
        if (rd_seen) chk("reg_rdata", rq.pop_front(), reg_rdata);
        if (rd_valid === 1'b1) chk("rd_data", dq.size() > 0 ? dq.pop_front() : ~rd_data, rd_data);
        if (memory_output_clock[0] === 1'b1) tick <= tick + 1;
        if (memory_output_clock[0] === 1'b1 && mem_pins.memory_chip_select_n !== sdp_pkg::CS_NONE
            && {mem_pins.sdram_row_strobe_n, mem_pins.sdram_column_strobe_n} === 2'b10) cmd_tick <= tick;
        if (direct_transfer_strobe === 1'b1 && !stb_d) stb_tick <= tick;
        if (direct_transfer_strobe === 1'b1 && !stb_d) stb_n <= stb_n + 1;
        stb_d <= direct_transfer_strobe;
        if (memory_data_bus_oe_n === 1'b0) drv_seen <= 1'b1;
        if (cyc > 20000) bad_count++;
        if (cyc > 20000) close_out();
    end

    // Main sequence
    initial
    begin
        int t0, tf, tg, n;
        logic [22:3] a;
        logic rdy;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        rr(sdp_pkg::REG_GLOBAL, sdp_pkg::GLB_RESET);
        rr(sdp_pkg::REG_DIRECT, sdp_pkg::DIR_RESET);
        rr(4'hc, 32'h0);
        rr(sdp_pkg::REG_STATUS, 32'h10);
        rw(sdp_pkg::REG_GLOBAL, 32'hffff_ffc6);
        rr(sdp_pkg::REG_GLOBAL, 32'h0000_0006);
        rw(sdp_pkg::REG_GLOBAL, 32'h0);
        $display("test registers done");
        refresh_req <= 1'b1;
        @(posedge ref_clk);
        refresh_req <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            a = seed[22:3];
            drv_seen <= 1'b0;
            access(1'b1, 1'b0, a, 1'b0);
            chk("data_driven", 32'h1, {31'h0, drv_seen});
            access(1'b0, 1'b0, a, 1'b0);
        end
        chk("strobe_count", 32'h0, stb_n);
        $display("test plain access done");
        rw(sdp_pkg::REG_GLOBAL, 32'h20);
        for (int l = 0; l < 8; l++)
        begin
            rw(sdp_pkg::REG_DIRECT, 32'(l % 4) * 32'h11);
            rr(sdp_pkg::REG_DIRECT, 32'(l % 4) * 32'h11);
            drv_seen <= 1'b0;
            access(l[2], 1'b1, seed[22:3], 1'b0);
            chk("strobe_lag", (l[2] ? 0 : sdp_pkg::CAS_LATENCY) + l % 4, stb_tick - cmd_tick);
            chk("strobe_count", l + 1, stb_n);
            if (l[2]) chk("data_driven", 32'h0, {31'h0, drv_seen});
        end
        $display("test direct transfer done");
        rw(sdp_pkg::REG_GLOBAL, 32'h5);
        bus_yield_request_n <= 1'b0;
        repeat (100) @(posedge ref_clk);
        chk("grant_inhibited", 32'h1, {31'h0, bus_yield_grant_n});
        bus_yield_request_n <= 1'b1;
        rw(sdp_pkg::REG_GLOBAL, 32'h14);
        access(1'b0, 1'b0, a, 1'b1);
        t0 = cyc;
        for (int i = 0; i < 300 && mem_pins_oe_n !== 1'b1; i++) @(posedge ref_clk);
        tf = cyc;
        for (int i = 0; i < 300 && bus_yield_grant_n !== 1'b0; i++) @(posedge ref_clk);
        tg = cyc;
        chk("float_delay", 32'h1, {31'h0, tf - t0 >= 8});
        chk("grant_delay", 32'h1, {31'h0, tg - tf <= 8 && bus_yield_grant_n === 1'b0});
        chk("pending_done", 32'h0, dq.size());
        chk("data_float", 32'h1, {31'h0, memory_data_bus_oe_n});
        chk("clock_float", 32'h2, {30'h0, memory_output_clock_oe_n});
        dq.push_back(shadow[int'(a)]);
        req_valid <= 1'b1;
        rdy = 1'b0;
        n = tick;
        repeat (60) @(posedge ref_clk) rdy |= (req_ready === 1'b1);
        chk("ready_in_hold", 32'h0, {31'h0, rdy});
        chk("clock_runs", 32'h1, {31'h0, tick - n >= 10});
        bus_yield_request_n <= 1'b1;
        t0 = cyc;
        for (int i = 0; i < 300 && mem_pins_oe_n !== 1'b0; i++) @(posedge ref_clk);
        tf = cyc;
        for (int i = 0; i < 300 && bus_yield_grant_n !== 1'b1; i++) @(posedge ref_clk);
        tg = cyc;
        chk("redrive_delay", 32'h1, {31'h0, tf - t0 >= 8 && tf - t0 <= 28});
        chk("ungrant_delay", 32'h1, {31'h0, tg - tf <= 8});
        wait_ready();
        req_valid <= 1'b0;
        repeat (150) @(posedge ref_clk);
        chk("resumed_read", 32'h0, dq.size());
        $display("test bus hold done");
        close_out();
    end
endmodule // sdp_port_bench
